// >>> logic/dis_pkg.sv
// constants for the interrupt status bank: offsets, masks, reset values
package dis_pkg;
    // register port widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // lane count behind the serial link, a plain default
    localparam int LANE_COUNT = 4;
    // stages of every pin synchroniser
    localparam int SYNC_STAGES = 2;

    // enable register offsets
    localparam logic [11:0] OFS_ENABLE_ZERO = 12'h01F;
    localparam logic [11:0] OFS_ENABLE_ONE = 12'h020;
    localparam logic [11:0] OFS_ENABLE_TWO = 12'h021;
    // status register offsets
    localparam logic [11:0] OFS_STATUS_ZERO = 12'h023;
    localparam logic [11:0] OFS_STATUS_ONE = 12'h024;
    localparam logic [11:0] OFS_STATUS_TWO = 12'h025;
    // lane queue full and empty views
    localparam logic [11:0] OFS_LANE_FULL = 12'h30C;
    localparam logic [11:0] OFS_LANE_EMPTY = 12'h30D;

    // implemented bits of each status byte, the same for its enable byte
    localparam logic [7:0] MASK_ZERO = 8'h03;
    localparam logic [7:0] MASK_ONE = 8'hFB;
    localparam logic [7:0] MASK_TWO = 8'h98;
    localparam logic [23:0] MASK_ALL = {MASK_TWO, MASK_ONE, MASK_ZERO};

    // bit positions in the flat 24-bit status vector (byte*8 + bit)
    localparam int POS_RATE_QUEUE_ERROR = 0;
    localparam int POS_LANE_QUEUE_ERROR = 1;
    localparam int POS_I_CHANNEL_SEQ = 8;
    localparam int POS_Q_CHANNEL_SEQ = 9;
    localparam int POS_OVERFLOW = 11;
    localparam int POS_RX_DATA_READY = 12;
    localparam int POS_DELAY_BUFFER = 13;
    localparam int POS_LANE_QUEUE_LEVEL = 14;
    localparam int POS_BAD_LINK_PARAM = 15;
    localparam int POS_MULTIFRAME_LOCK = 19;
    localparam int POS_OSC_ALIGN_TRIP = 20;
    localparam int POS_POWER_THRESHOLD = 23;

    // values after reset, and the answer to an unmapped read
    localparam logic [23:0] RESET_ENABLES = 24'h000000;
    localparam logic [7:0] RESET_READ_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// >>> logic/dis_status_cell.sv
// one status bit: live view, or rising-edge latch cleared by writing one
module dis_status_cell
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // condition and control
    input wire logic cond,
    input wire logic enable,
    input wire logic clear,
    // results
    output logic status,
    output logic latched
);
    logic condPrev;
    logic rise;
    logic next_latched;

    // edge seen only on the already synchronised condition
    assign rise = cond & ~condPrev;
    // a rise in the clearing cycle wins so no event is lost
    assign next_latched = enable & (rise | (latched & ~clear));
    // enable low shows the live condition, high shows the latch
    assign status = enable ? latched : cond;

    // edge history and latch
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            condPrev <= 1'b0;
            latched <= 1'b0;
        end
        else
        begin
            condPrev <= cond;
            latched <= next_latched;
        end
    end
endmodule

// >>> logic/dis_status_bank.sv
// interrupt status and enable registers with the active-low interrupt line
// Function
// - enable low, the status bit shows the live condition.
// - enable high, a rising edge latches the bit and pulls the interrupt low.
// - writing one to a latched bit clears it.
// - lane queue error rises when any lane queue is full or empty while the link is enabled.
// - lane queue error holds until the link is disabled.
// - lane full states read at 0x30C, empty states at 0x30D.
// - lane queue error is bit 1 of the status byte before 0x024.
// - rate queue error is bit 0 of that byte, latching and clear-by-one.
// - bit 7 at 0x024 flags a bad link parameter.
// - bit 6 at 0x024 flags a lane queue empty or full.
// - bit 5 at 0x024 flags delay buffer empty or full.
// - bit 4 at 0x024 flags received data ready.
// - bit 3 at 0x024 flags a transmit datapath overflow.
// - bits 1 and 0 at 0x024 flag Q and I sequence check failures.
// - bit 0 at 0x024 uses its own I-channel enable.
// - bit 7 at 0x025 flags input power over the detection threshold.
// - bit 4 at 0x025 flags the oscillator alignment trip.
// - bit 3 at 0x025 flags multiframe alignment locked.
// - latch enables sit in separate read-write enable registers.
module dis_status_bank
    import dis_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    // serial link state
    input wire logic linkEnable,
    input wire logic [LANE_COUNT-1:0] laneFull,
    input wire logic [LANE_COUNT-1:0] laneEmpty,
    // event conditions from the core
    input wire logic rateQueueError,
    input wire logic badLinkParameter,
    input wire logic delayBufferLevel,
    input wire logic rxDataReady,
    input wire logic datapathOverflow,
    input wire logic qChannelSequenceFail,
    input wire logic iChannelSequenceFail,
    input wire logic powerThresholdError,
    input wire logic oscillatorAlignTrip,
    input wire logic multiframeAlignLocked,
    // interrupt line
    output logic irqN
);
    localparam int PIN_W = 2 * LANE_COUNT + 11;

    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] syncFirst;
    logic [PIN_W-1:0] syncSecond;
    logic [LANE_COUNT-1:0] laneFullSync;
    logic [LANE_COUNT-1:0] laneEmptySync;
    logic linkEnableSync;
    logic anyLaneLevel;
    logic laneQueueError;
    logic next_laneQueueError;
    logic [23:0] condBits;
    logic [23:0] enableBits;
    logic [23:0] next_enableBits;
    logic [23:0] clearBits;
    logic [23:0] statusBits;
    logic [23:0] latchedBits;
    logic hitEnZero;
    logic hitEnOne;
    logic hitEnTwo;
    logic hitStZero;
    logic hitStOne;
    logic hitStTwo;
    logic hitLaneFull;
    logic hitLaneEmpty;
    logic [7:0] readMux;
    logic next_irqN;

    // every input from outside the clock domain, gathered for syncing
    assign pinRaw = {laneFull, laneEmpty, linkEnable, rateQueueError,
        badLinkParameter, delayBufferLevel, rxDataReady, datapathOverflow,
        qChannelSequenceFail, iChannelSequenceFail, powerThresholdError,
        oscillatorAlignTrip, multiframeAlignLocked};

    // two-flop synchroniser; only the second stage feeds logic
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            syncFirst <= '0;
            syncSecond <= '0;
        end
        else
        begin
            syncFirst <= pinRaw;
            syncSecond <= syncFirst;
        end
    end

    // unpack the synchronised inputs
    assign laneFullSync = syncSecond[PIN_W-1 -: LANE_COUNT];
    assign laneEmptySync = syncSecond[PIN_W-1-LANE_COUNT -: LANE_COUNT];
    assign linkEnableSync = syncSecond[10];

    // any lane queue at a limit is the live level condition
    assign anyLaneLevel = (|laneFullSync) | (|laneEmptySync);

    // the error sticks while the link runs; only a link drop removes it,
    // so a write-one clear alone will not make it go away if enable is low
    assign next_laneQueueError = linkEnableSync
        & (laneQueueError | anyLaneLevel);

    // sticky lane queue error
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            laneQueueError <= 1'b0;
        end
        else
        begin
            laneQueueError <= next_laneQueueError;
        end
    end

    // live conditions placed at their status positions
    always_comb
    begin
        condBits = '0;
        condBits[POS_RATE_QUEUE_ERROR] = syncSecond[9];
        condBits[POS_LANE_QUEUE_ERROR] = laneQueueError;
        condBits[POS_BAD_LINK_PARAM] = syncSecond[8];
        condBits[POS_LANE_QUEUE_LEVEL] = anyLaneLevel;
        condBits[POS_DELAY_BUFFER] = syncSecond[7];
        condBits[POS_RX_DATA_READY] = syncSecond[6];
        condBits[POS_OVERFLOW] = syncSecond[5];
        condBits[POS_Q_CHANNEL_SEQ] = syncSecond[4];
        condBits[POS_I_CHANNEL_SEQ] = syncSecond[3];
        condBits[POS_POWER_THRESHOLD] = syncSecond[2];
        condBits[POS_OSC_ALIGN_TRIP] = syncSecond[1];
        condBits[POS_MULTIFRAME_LOCK] = syncSecond[0];
    end

    // address decode
    assign hitEnZero = regAddr == OFS_ENABLE_ZERO;
    assign hitEnOne = regAddr == OFS_ENABLE_ONE;
    assign hitEnTwo = regAddr == OFS_ENABLE_TWO;
    assign hitStZero = regAddr == OFS_STATUS_ZERO;
    assign hitStOne = regAddr == OFS_STATUS_ONE;
    assign hitStTwo = regAddr == OFS_STATUS_TWO;
    assign hitLaneFull = regAddr == OFS_LANE_FULL;
    assign hitLaneEmpty = regAddr == OFS_LANE_EMPTY;

    // enable writes; reserved bits are masked so they read back zero
    always_comb
    begin
        next_enableBits = enableBits;
        if (regWrEn && hitEnZero)
        begin
            next_enableBits[7:0] = regWrData & MASK_ZERO;
        end
        if (regWrEn && hitEnOne)
        begin
            next_enableBits[15:8] = regWrData & MASK_ONE;
        end
        if (regWrEn && hitEnTwo)
        begin
            next_enableBits[23:16] = regWrData & MASK_TWO;
        end
    end

    // enable register storage
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            enableBits <= RESET_ENABLES;
        end
        else
        begin
            enableBits <= next_enableBits;
        end
    end

    // write-one-to-clear pulses, one cycle, per status byte
    assign clearBits = {
        (regWrEn && hitStTwo) ? regWrData : 8'h00,
        (regWrEn && hitStOne) ? regWrData : 8'h00,
        (regWrEn && hitStZero) ? regWrData : 8'h00} & MASK_ALL;

    // one cell per implemented bit, each with its own enable
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++)
        begin : g_bit
            if (MASK_ALL[gi])
            begin : g_cell
                dis_status_cell u_cell
                (
                    .clk_sys(clk_sys),
                    .rstn(rstn),
                    .cond(condBits[gi]),
                    .enable(enableBits[gi]),
                    .clear(clearBits[gi]),
                    .status(statusBits[gi]),
                    .latched(latchedBits[gi])
                );
            end
            else
            begin : g_none
                // reserved positions read zero and never interrupt
                assign statusBits[gi] = 1'b0;
                assign latchedBits[gi] = 1'b0;
            end
        end
    endgenerate

    // line held low while anything is latched
    assign next_irqN = ~(|latchedBits);

    // registered interrupt line, high out of reset
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            irqN <= 1'b1;
        end
        else
        begin
            irqN <= next_irqN;
        end
    end

    // read selection; unmapped addresses answer zero
    assign readMux =
        hitEnZero ? enableBits[7:0] :
        hitEnOne ? enableBits[15:8] :
        hitEnTwo ? enableBits[23:16] :
        hitStZero ? statusBits[7:0] :
        hitStOne ? statusBits[15:8] :
        hitStTwo ? statusBits[23:16] :
        hitLaneFull ? {{(8-LANE_COUNT){1'b0}}, laneFullSync} :
        hitLaneEmpty ? {{(8-LANE_COUNT){1'b0}}, laneEmptySync} :
        UNMAPPED_READ;

    // read data captured on the clock edge that samples the read strobe, then held
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdData <= RESET_READ_DATA;
        end
        else if (regRdEn)
        begin
            regRdData <= readMux;
        end
    end
endmodule

// >>> tb/dis_host_model.sv
// host model: drives the register port of the interrupt status bank
module dis_host_model
    import dis_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register port towards the device
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial
    begin
        regAddr = '0;
        regWrData = 8'hA5;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // one write pulse, launched and dropped on falling edges
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
        regWrData = ~d; // released data never shows the last value
    endtask

    // one read pulse; data is taken once the answering edge has passed
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        d = regRdData;
    endtask

    // acknowledge one latched bit by writing a one to its place
    task automatic clear(input int pos);
        wr(OFS_STATUS_ZERO + 12'(pos / 8), 8'(1 << (pos % 8)));
    endtask
endmodule

// >>> tb/dis_status_bank_checker.sv
// checker: register port and interrupt line of the status bank
module dis_status_bank_checker
    import dis_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData,
    // watched event and interrupt line
    input wire logic iChannelSequenceFail,
    input wire logic irqN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic [23:0] enShadow;

    // shadow of the enable bytes, so live and latched modes can be told
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            enShadow <= RESET_ENABLES;
        else if (regWrEn && regAddr == OFS_ENABLE_ZERO)
            enShadow[7:0] <= regWrData & MASK_ZERO;
        else if (regWrEn && regAddr == OFS_ENABLE_ONE)
            enShadow[15:8] <= regWrData & MASK_ONE;
        else if (regWrEn && regAddr == OFS_ENABLE_TWO)
            enShadow[23:16] <= regWrData & MASK_TWO;
    end

    // enable held and no write may clear the latch meanwhile
    sequence s_quiet;
        (enShadow[POS_I_CHANNEL_SEQ] && !regWrEn) [*6];
    endsequence
    sequence s_arm;
        $rose(iChannelSequenceFail) && enShadow[POS_I_CHANNEL_SEQ] && !regWrEn;
    endsequence

    // a dropped enable frees its latch one edge late, the line one more
    property p_no_enable;
        enShadow == 24'h000000 && $past(enShadow) == 24'h000000
            && $past(enShadow, 2) == 24'h000000 |-> irqN;
    endproperty
    property p_latch;
        s_arm ##1 s_quiet |-> !irqN;
    endproperty
    property p_irq_rise;
        $rose(irqN) |-> $past(regWrEn) || $past(regWrEn, 2)
            || $past(regWrEn, 3);
    endproperty
    property p_irq_stay;
        !irqN && !regWrEn && !$past(regWrEn) && !$past(regWrEn, 2)
            |=> !irqN;
    endproperty
    property p_lane_view;
        regRdEn && regAddr == OFS_LANE_FULL |=> regRdData[7:4] == 4'h0;
    endproperty
    property p_rsv_one;
        regRdEn && regAddr == OFS_STATUS_ONE
            |=> (regRdData & ~MASK_ONE) == 8'h00;
    endproperty
    property p_rsv_two;
        regRdEn && regAddr == OFS_STATUS_TWO
            |=> (regRdData & ~MASK_TWO) == 8'h00;
    endproperty
    property p_enable_read;
        regRdEn && !regWrEn && regAddr == OFS_ENABLE_ONE
            |=> regRdData == enShadow[15:8];
    endproperty

    a_no_enable: assert property (p_no_enable)
        else $error("interrupt low with every enable clear");
    a_latch: assert property (p_latch)
        else $error("rising condition did not pull the interrupt low");
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt released without a write");
    a_irq_stay: assert property (p_irq_stay)
        else $error("interrupt released while a bit stayed latched");
    a_lane_view: assert property (p_lane_view)
        else $error("lane full view shows absent lanes");
    a_rsv_one: assert property (p_rsv_one)
        else $error("reserved bit of status one reads nonzero");
    a_rsv_two: assert property (p_rsv_two)
        else $error("reserved bits of status two read nonzero");
    a_enable_read: assert property (p_enable_read)
        else $error("enable byte reads back wrong");
endmodule

bind dis_status_bank dis_status_bank_checker chk_u
(
    .clk_sys(clk_sys),
    .rstn(rstn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .iChannelSequenceFail(iChannelSequenceFail),
    .irqN(irqN)
);

// >>> tb/dac_interrupt_status_bank_test.sv
// testbench: live, latched and cleared behaviour of the status bank
module dac_interrupt_status_bank_test
    import dis_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    // event inputs in table order, with their status bit positions
    localparam int POS [10] = '{POS_RATE_QUEUE_ERROR, POS_I_CHANNEL_SEQ,
        POS_Q_CHANNEL_SEQ, POS_OVERFLOW, POS_RX_DATA_READY, POS_DELAY_BUFFER,
        POS_BAD_LINK_PARAM, POS_POWER_THRESHOLD, POS_OSC_ALIGN_TRIP,
        POS_MULTIFRAME_LOCK};
    localparam logic [11:0] REGS [9] = '{12'h01F, 12'h020, 12'h021, 12'h023,
        12'h024, 12'h025, 12'h30C, 12'h30D, 12'h022};

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic linkEnable = 1'b0;
    logic [LANE_COUNT-1:0] laneFull = '0;
    logic [LANE_COUNT-1:0] laneEmpty = '0;
    logic [9:0] ev = '0;
    logic [23:0] v;
    logic [7:0] b;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    wire [ADDR_W-1:0] regAddr;
    wire [DATA_W-1:0] regWrData;
    wire [DATA_W-1:0] regRdData;
    wire regWrEn;
    wire regRdEn;
    wire irqN;

    dis_host_model hostU (.clk_sys(clk_sys), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData));

    dis_status_bank dut_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .linkEnable(linkEnable), .laneFull(laneFull),
        .laneEmpty(laneEmpty), .rateQueueError(ev[0]),
        .iChannelSequenceFail(ev[1]), .qChannelSequenceFail(ev[2]),
        .datapathOverflow(ev[3]), .rxDataReady(ev[4]),
        .delayBufferLevel(ev[5]), .badLinkParameter(ev[6]),
        .powerThresholdError(ev[7]), .oscillatorAlignTrip(ev[8]),
        .multiframeAlignLocked(ev[9]), .irqN(irqN));

    // 100 MHz clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // a hang is cut short well past the expected run length
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            summarize();
        end
    end

    // expected status vector for a set of live conditions
    function automatic logic [23:0] expv(input logic [9:0] e);
        logic [23:0] r;
        r = '0;
        for (int i = 0; i < 10; i++)
            r[POS[i]] = e[i];
        return r;
    endfunction

    task automatic check(input string what, input logic [23:0] seen,
        input logic [23:0] expd);
        num_checks++;
        if (seen !== expd)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
        end
    endtask

    task automatic rd3(output logic [23:0] r);
        hostU.rd(OFS_STATUS_ZERO, r[7:0]);
        hostU.rd(OFS_STATUS_ONE, r[15:8]);
        hostU.rd(OFS_STATUS_TWO, r[23:16]);
    endtask

    task automatic waitn(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic summarize();
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence: reset, live view, lane queues, latching and clearing
    initial
    begin
        void'($urandom(60));
        waitn(4);
        rstn = 1'b1;
        waitn(2);
        foreach (REGS[i])
        begin
            hostU.rd(REGS[i], b);
            check("reset value", b, 24'h0);
        end
        repeat (8)
        begin
            ev = 10'($urandom);
            waitn(4);
            rd3(v);
            check("live status", v, expv(ev));
            check("live irq", irqN, 24'h1);
        end
        ev = '0;
        linkEnable = 1'b1;
        laneFull = 4'h2;
        laneEmpty = 4'h8;
        waitn(4);
        hostU.rd(OFS_LANE_FULL, b);
        check("lane full", b, 24'h02);
        hostU.rd(OFS_LANE_EMPTY, b);
        check("lane empty", b, 24'h08);
        rd3(v);
        check("lane live", v, 24'h004002);
        laneFull = '0;
        laneEmpty = '0;
        waitn(4);
        rd3(v);
        check("lane sticky", v, 24'h000002);
        linkEnable = 1'b0; // link dropped to remove the error
        waitn(4);
        rd3(v);
        check("lane removed", v, 24'h0);
        hostU.wr(OFS_ENABLE_ZERO, 8'hFF);
        hostU.wr(OFS_ENABLE_ONE, 8'hFF);
        hostU.wr(OFS_ENABLE_TWO, 8'hFF);
        hostU.rd(OFS_ENABLE_TWO, b);
        check("enable two", b, MASK_TWO);
        for (int i = 0; i < 10; i++)
        begin
            ev[i] = 1'b1;
            waitn(7);
            check("irq set", irqN, 24'h0);
            ev[i] = 1'b0;
            waitn(4);
            rd3(v);
            check("latched", v, 24'h1 << POS[i]);
            hostU.clear(POS[i]);
            waitn(3);
            check("irq cleared", irqN, 24'h1);
            rd3(v);
            check("bit cleared", v, 24'h0);
        end
        linkEnable = 1'b1;
        laneFull = 4'h1;
        waitn(2);
        laneFull = '0;
        waitn(6);
        rd3(v);
        check("lane latched", v, 24'h004002);
        hostU.clear(POS_LANE_QUEUE_LEVEL);
        waitn(3);
        check("irq held", irqN, 24'h0);
        hostU.clear(POS_LANE_QUEUE_ERROR);
        waitn(3);
        check("irq free", irqN, 24'h1);
        linkEnable = 1'b0;
        ev[2] = 1'b1;
        waitn(7);
        hostU.wr(OFS_ENABLE_ONE, 8'h00);
        waitn(3);
        check("irq enable off", irqN, 24'h1);
        rd3(v);
        check("live again", v, expv(ev));
        // only the I bit latches; Q beside it stays a live view
        hostU.wr(OFS_ENABLE_ONE, 8'h01);
        ev[1] = 1'b1;
        waitn(7);
        ev[1] = 1'b0;
        waitn(4);
        rd3(v);
        check("own enable", v, 24'h000300);
        check("own enable irq", irqN, 24'h0);
        hostU.clear(POS_I_CHANNEL_SEQ);
        waitn(3);
        check("own enable freed", irqN, 24'h1);
        summarize();
    end
endmodule
